// ---- logic/dswa_top.sv ----
/*
  Drive status word assembler: builds the general status word and bits 0
  to 5 of the motion status word from drive state pins, latches both on
  each telegram cycle and serves them over an Avalon-MM slave.
  Assumes drive state pins are asynchronous; i_telegram_cycle and
  i_fault_ack are one-cycle pulses from logic on i_clock.
*/
// Summary of operation
// RULE1: Bits 0-4 of the general word carry the effective data set index.
// RULE2: Bits 5-6 of the general word carry the alarm class 0 to 3.
// RULE3: Bit 7 of the general word is 1 exactly while axis parking is on.
// RULE4: Bit 8 of the general word is 1 while travelling to a fixed stop.
// RULE5: Bit 11 of the general word is 1 while a data set changeover runs.
// RULE6: Bits 12-15 of the general word carry a 4-bit sign-of-life count.
// RULE7: The count steps by one mod 16 per telegram; bits 9-10 read zero.
// RULE8: Motion bit 0 needs power, init, contactor released, pulses off.
// RULE9: Motion bit 1 needs energized power stage, field and switch-on.
// RULE10: Motion bit 2 needs pulses enabled and ramping, else it is 0.
// RULE11: Motion bit 3 is set while faulted; ack and clear lead to inhibit. Code: bit 3 follows the fault buffer, not the faulted state.
// RULE12: Motion bit 3 is 0 exactly when the fault buffer holds no entry.
// RULE13: Motion bit 4 is 0 while coast stop is commanded, else 1.
// RULE14: Motion bit 5 is 1 while no quick stop is commanded.
// RULE15: Motion bit 5 is 0 while a quick stop is commanded.
`timescale 1ns/1ps
`default_nettype none
module dswa_top
  import dswa_pkg::*;
#(
  parameter int unsigned FAULT_ENTRIES = 8
) (
  input wire logic i_clock,                  // 10 MHz system clock
  input wire logic i_reset,                  // Synchronous reset, high
  input wire logic [4:0] i_avs_address,      // Byte address
  input wire logic i_avs_read,               // Read request
  input wire logic i_avs_write,              // Write request
  input wire logic [31:0] i_avs_writedata,   // Write data
  input wire logic [3:0] i_avs_byteenable,   // Byte lanes
  output logic [31:0] o_avs_readdata,        // Read data
  output logic o_avs_waitrequest,            // Stall
  output logic o_irq,                        // Level interrupt
  input wire logic i_telegram_cycle,         // Telegram cycle pulse
  input wire logic i_fault_ack,              // Fault acknowledge pulse
  input wire logic [4:0] i_drive_data_set,   // Effective data set index
  input wire logic [1:0] i_alarm_class,      // Alarm stage
  input wire logic i_axis_parking,           // Axis parking active
  input wire logic i_fixed_stop,             // Travel to fixed stop
  input wire logic i_changeover,             // Data set changeover active
  input wire logic i_power_present,          // Supply on
  input wire logic i_electronics_ready,      // Electronics initialised
  input wire logic i_contactor_released,     // Line contactor released
  input wire logic i_pulses_inhibited,       // Output pulses inhibited
  input wire logic i_power_stage_on,         // Power stage energised
  input wire logic i_field_building,         // Field being built up
  input wire logic i_switch_on_command,      // Switch-on command given
  input wire logic i_pulses_enabled,         // Pulses enabled
  input wire logic i_ramp_active,            // Ramping to setpoint
  input wire logic i_coast_stop_command,     // Coast stop, high active
  input wire logic i_quick_stop_command,     // Quick stop, high active
  input wire logic [FAULT_ENTRIES-1:0] i_fault_buffer, // Active entries
  output logic [15:0] o_general_status_word, // Latched general word
  output logic [15:0] o_motion_status_word   // Latched motion word
);
  localparam int unsigned SYNC_W = 21 + FAULT_ENTRIES;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic [4:0] dset_s;
  logic [1:0] alarm_s;
  logic park_s;
  logic fixstop_s;
  logic chg_s;
  logic power_s;
  logic elec_s;
  logic contactor_s;
  logic pinh_s;
  logic pstage_s;
  logic field_s;
  logic son_s;
  logic pen_s;
  logic ramp_s;
  logic coast_s;
  logic qstop_s;
  logic [FAULT_ENTRIES-1:0] fbuf_s;

  assign pins_raw = {i_fault_buffer, i_quick_stop_command,
                     i_coast_stop_command, i_ramp_active, i_pulses_enabled,
                     i_switch_on_command, i_field_building, i_power_stage_on,
                     i_pulses_inhibited, i_contactor_released,
                     i_electronics_ready, i_power_present, i_changeover,
                     i_fixed_stop, i_axis_parking, i_alarm_class,
                     i_drive_data_set};

  dswa_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_async(pins_raw),
    .o_sync(pins_s)
  );

  assign dset_s = pins_s[4:0];
  assign alarm_s = pins_s[6:5];
  assign park_s = pins_s[7];
  assign fixstop_s = pins_s[8];
  assign chg_s = pins_s[9];
  assign power_s = pins_s[10];
  assign elec_s = pins_s[11];
  assign contactor_s = pins_s[12];
  assign pinh_s = pins_s[13];
  assign pstage_s = pins_s[14];
  assign field_s = pins_s[15];
  assign son_s = pins_s[16];
  assign pen_s = pins_s[17];
  assign ramp_s = pins_s[18];
  assign coast_s = pins_s[19];
  assign qstop_s = pins_s[20];
  assign fbuf_s = pins_s[SYNC_W-1:21];

  // Control and interrupt registers
  logic [DSWA_CTL_W-1:0] control_q;
  logic [DSWA_IRQ_W-1:0] irq_status_q;
  logic [DSWA_IRQ_W-1:0] irq_mask_q;
  logic [DSWA_IRQ_W-1:0] irq_event;
  logic [DSWA_IRQ_W-1:0] irq_clear;

  // Sign of life and fault state
  logic [3:0] sol_q;
  logic [3:0] sol_d;
  dswa_state_e state_q;
  dswa_state_e state_d;
  logic fault_any;

  // Status words
  logic [15:0] gsw_live;
  logic [15:0] msw_live;

  // Bus handshake
  logic bus_req;
  logic ack_q;
  logic bus_wr_take;

  // RULE12: fault bit tracks buffer
  assign fault_any = |fbuf_s;

  // RULE7: step count per telegram
  always_comb begin
    sol_d = sol_q;
    if (i_telegram_cycle && control_q[DSWA_CTL_SOL_EN] &&
        !control_q[DSWA_CTL_SOL_HOLD]) begin
      sol_d = sol_q + 4'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sol_q <= DSWA_SOL_RESET;
    end else begin
      sol_q <= sol_d;
    end
  end

  // RULE11: faulted, then inhibited after ack and cleared cause
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DSWA_ST_RUN: begin
        if (fault_any) begin
          state_d = DSWA_ST_FAULTED;
        end
      end
      DSWA_ST_FAULTED: begin
        if (i_fault_ack && !fault_any) begin
          state_d = DSWA_ST_INHIBITED;
        end
      end
      DSWA_ST_INHIBITED: begin
        // Restart only after the switch-on command has been dropped
        if (fault_any) begin
          state_d = DSWA_ST_FAULTED;
        end else if (!son_s) begin
          state_d = DSWA_ST_RUN;
        end
      end
      default: begin
        state_d = DSWA_ST_FAULTED;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= DSWA_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    gsw_live = DSWA_WORD_RESET;
    // RULE1: data set index
    gsw_live[DSWA_GSW_DSET_LSB +: DSWA_GSW_DSET_W] = dset_s;
    // RULE2: alarm class field
    gsw_live[DSWA_GSW_ALARM_LSB +: DSWA_GSW_ALARM_W] = alarm_s;
    // RULE3: parking flag
    gsw_live[DSWA_GSW_PARK] = park_s;
    // RULE4: fixed stop flag
    gsw_live[DSWA_GSW_FIXSTOP] = fixstop_s;
    // RULE7: reserved bits zero
    gsw_live[DSWA_GSW_RSV0] = 1'b0;
    gsw_live[DSWA_GSW_RSV1] = 1'b0;
    // RULE5: changeover flag
    gsw_live[DSWA_GSW_CHANGEOVER] = chg_s;
    // RULE6: sign of life field
    gsw_live[DSWA_GSW_SOL_LSB +: DSWA_GSW_SOL_W] = sol_q;
  end

  always_comb begin
    msw_live = DSWA_WORD_RESET;
    // RULE8: ready to switch on
    msw_live[DSWA_MSW_READY_ON] = power_s && elec_s && contactor_s &&
                                  pinh_s && (state_q == DSWA_ST_RUN);
    // RULE9: ready for operation
    msw_live[DSWA_MSW_READY_OP] = pstage_s && field_s && son_s &&
                                  (state_q == DSWA_ST_RUN);
    // RULE10: operation enabled
    msw_live[DSWA_MSW_OP_EN] = pen_s && ramp_s && son_s &&
                               (state_q == DSWA_ST_RUN);
    // RULE11: fault bit
    msw_live[DSWA_MSW_FAULT] = fault_any;
    // RULE13: coast stop, low active
    msw_live[DSWA_MSW_NO_COAST] = !coast_s;
    // RULE14: quick stop idle is 1
    // RULE15: quick stop active is 0
    msw_live[DSWA_MSW_NO_QSTOP] = !qstop_s;
  end

  // Latch per telegram so both words in one frame are consistent
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_general_status_word <= DSWA_WORD_RESET;
      o_motion_status_word <= DSWA_WORD_RESET;
    end else if (i_telegram_cycle) begin
      o_general_status_word <= {sol_d, gsw_live[11:0]};
      o_motion_status_word <= msw_live;
    end
  end

  // Edge history for interrupt events
  logic fault_prev_q;
  logic stop_prev_q;
  logic chg_prev_q;
  logic [1:0] alarm_prev_q;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      fault_prev_q <= 1'b0;
      stop_prev_q <= 1'b0;
      chg_prev_q <= 1'b0;
      alarm_prev_q <= 2'h0;
    end else begin
      fault_prev_q <= fault_any;
      stop_prev_q <= coast_s || qstop_s;
      chg_prev_q <= chg_s;
      alarm_prev_q <= alarm_s;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[DSWA_IRQ_FAULT_SET] = fault_any && !fault_prev_q;
    irq_event[DSWA_IRQ_FAULT_DONE] = (state_q == DSWA_ST_FAULTED) &&
                                     (state_d == DSWA_ST_INHIBITED);
    irq_event[DSWA_IRQ_STOP] = (coast_s || qstop_s) && !stop_prev_q;
    irq_event[DSWA_IRQ_CHG_END] = chg_prev_q && !chg_s;
    irq_event[DSWA_IRQ_ALARM] = alarm_s != alarm_prev_q;
  end

  // Avalon: one wait cycle, answer on the second edge
  assign bus_req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = bus_req && !ack_q;
  assign bus_wr_take = i_avs_write && ack_q;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end

  always_comb begin
    irq_clear = '0;
    if (bus_wr_take && i_avs_address == DSWA_OFF_IRQ_STATUS &&
        i_avs_byteenable[0]) begin
      irq_clear = i_avs_writedata[DSWA_IRQ_W-1:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      control_q <= DSWA_CTL_RESET;
      irq_mask_q <= DSWA_IRQ_MASK_RESET;
    end else if (bus_wr_take && i_avs_byteenable[0]) begin
      if (i_avs_address == DSWA_OFF_CONTROL) begin
        control_q <= i_avs_writedata[DSWA_CTL_W-1:0];
      end
      if (i_avs_address == DSWA_OFF_IRQ_MASK) begin
        irq_mask_q <= i_avs_writedata[DSWA_IRQ_W-1:0];
      end
    end
  end

  assign o_irq = |(irq_status_q & irq_mask_q);

  // Read data sampled in the wait cycle, stands in the answer cycle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read && !ack_q) begin
      unique case (i_avs_address)
        DSWA_OFF_GENERAL: o_avs_readdata <= {16'h0000,
                                             o_general_status_word};
        DSWA_OFF_MOTION: o_avs_readdata <= {16'h0000,
                                            o_motion_status_word};
        DSWA_OFF_CONTROL: o_avs_readdata <= {30'h00000000, control_q};
        DSWA_OFF_IRQ_STATUS: o_avs_readdata <= {27'h0000000,
                                                irq_status_q};
        DSWA_OFF_IRQ_MASK: o_avs_readdata <= {27'h0000000, irq_mask_q};
        DSWA_OFF_LIVE_GENERAL: o_avs_readdata <= {16'h0000, gsw_live};
        DSWA_OFF_LIVE_MOTION: o_avs_readdata <= {16'h0000, msw_live};
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- logic/dswa_pkg.sv ----
/*
  Constants for the drive status word assembler: register byte offsets,
  status word field positions, interrupt bits and reset values.
  Assumes a 32-bit Avalon-MM slave port with word-aligned byte addresses.
*/
`default_nettype none
package dswa_pkg;
  localparam int unsigned DSWA_ADDR_W = 5;
  localparam int unsigned DSWA_DATA_W = 32;
  localparam int unsigned DSWA_WORD_W = 16;

  // Register byte offsets
  localparam logic [4:0] DSWA_OFF_GENERAL = 5'h00;
  localparam logic [4:0] DSWA_OFF_MOTION = 5'h04;
  localparam logic [4:0] DSWA_OFF_CONTROL = 5'h08;
  localparam logic [4:0] DSWA_OFF_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] DSWA_OFF_IRQ_MASK = 5'h10;
  localparam logic [4:0] DSWA_OFF_LIVE_GENERAL = 5'h14;
  localparam logic [4:0] DSWA_OFF_LIVE_MOTION = 5'h18;

  // General status word fields
  localparam int unsigned DSWA_GSW_DSET_LSB = 0;
  localparam int unsigned DSWA_GSW_DSET_W = 5;
  localparam int unsigned DSWA_GSW_ALARM_LSB = 5;
  localparam int unsigned DSWA_GSW_ALARM_W = 2;
  localparam int unsigned DSWA_GSW_PARK = 7;
  localparam int unsigned DSWA_GSW_FIXSTOP = 8;
  localparam int unsigned DSWA_GSW_RSV0 = 9;
  localparam int unsigned DSWA_GSW_RSV1 = 10;
  localparam int unsigned DSWA_GSW_CHANGEOVER = 11;
  localparam int unsigned DSWA_GSW_SOL_LSB = 12;
  localparam int unsigned DSWA_GSW_SOL_W = 4;

  // Motion status word fields
  localparam int unsigned DSWA_MSW_READY_ON = 0;
  localparam int unsigned DSWA_MSW_READY_OP = 1;
  localparam int unsigned DSWA_MSW_OP_EN = 2;
  localparam int unsigned DSWA_MSW_FAULT = 3;
  localparam int unsigned DSWA_MSW_NO_COAST = 4;
  localparam int unsigned DSWA_MSW_NO_QSTOP = 5;

  // Control register bits
  localparam int unsigned DSWA_CTL_SOL_EN = 0;
  localparam logic [1:0] DSWA_CTL_RESET = 2'h1;
  localparam int unsigned DSWA_CTL_W = 2;
  localparam int unsigned DSWA_CTL_SOL_HOLD = 1;

  // Interrupt status bits
  localparam int unsigned DSWA_IRQ_W = 5;
  localparam int unsigned DSWA_IRQ_FAULT_SET = 0;
  localparam int unsigned DSWA_IRQ_FAULT_DONE = 1;
  localparam int unsigned DSWA_IRQ_STOP = 2;
  localparam int unsigned DSWA_IRQ_CHG_END = 3;
  localparam int unsigned DSWA_IRQ_ALARM = 4;
  localparam logic [4:0] DSWA_IRQ_MASK_RESET = 5'h00;

  localparam logic [3:0] DSWA_SOL_RESET = 4'h0;
  localparam logic [15:0] DSWA_WORD_RESET = 16'h0000;

  // Fault handling states
  typedef enum logic [1:0] {
    DSWA_ST_RUN = 2'b00,
    DSWA_ST_FAULTED = 2'b01,
    DSWA_ST_INHIBITED = 2'b10
  } dswa_state_e;
endpackage
`default_nettype wire

// ---- logic/dswa_sync.sv ----
/*
  Three-stage input synchroniser for a vector of pin levels.
  Assumes levels that change slowly against i_clock; the first stage is
  read only by the second stage.
*/
`timescale 1ns/1ps
`default_nettype none
module dswa_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_clock,              // System clock
  input wire logic i_reset,              // Synchronous reset, high
  input wire logic [WIDTH-1:0] i_async,  // Pin levels
  output logic [WIDTH-1:0] o_sync        // Settled levels
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end else begin
      stage1_q <= i_async;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_sync <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          o_sync[i] <= stage3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/dswa_assertions.sv ----
/*
  Checker for the drive status word assembler top ports.
  Assumes drive pins settle within five clocks of a change.
*/
`timescale 1ns/1ps
`default_nettype none
module dswa_checker #(
  parameter int unsigned FAULT_ENTRIES = 8
) (
  input wire logic i_clock,                   // Clock
  input wire logic i_reset,                   // Reset
  input wire logic i_telegram_cycle,          // Telegram pulse
  input wire logic [4:0] i_drive_data_set,    // Data set
  input wire logic [1:0] i_alarm_class,       // Alarm stage
  input wire logic i_axis_parking,            // Parking
  input wire logic i_fixed_stop,              // Fixed stop
  input wire logic i_changeover,              // Changeover
  input wire logic i_coast_stop_command,      // Coast stop
  input wire logic i_quick_stop_command,      // Quick stop
  input wire logic [FAULT_ENTRIES-1:0] i_fault_buffer, // Faults
  input wire logic [15:0] o_general_status_word, // General word
  input wire logic [15:0] o_motion_status_word   // Motion word
);
  logic [FAULT_ENTRIES+11:0] pins;
  logic [FAULT_ENTRIES+11:0] pins_q;
  logic [2:0] calm_q;
  logic any_fault;
  logic ok;
  assign pins = {i_drive_data_set, i_alarm_class, i_axis_parking,
    i_fixed_stop, i_changeover, i_coast_stop_command,
    i_quick_stop_command, i_fault_buffer};
  assign any_fault = |i_fault_buffer;
  // Pins are synchronised, so only judge telegrams after a calm spell
  assign ok = i_telegram_cycle && (calm_q >= 3'h5);
  always_ff @(posedge i_clock) begin
    pins_q <= pins;
    if (i_reset || (pins != pins_q)) begin
      calm_q <= 3'h0;
    end else if (calm_q != 3'h7) begin
      calm_q <= calm_q + 3'h1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  AST_DSET: assert property (
    ok |=> o_general_status_word[4:0] == $past(i_drive_data_set))
    else $error("data set index wrong");
  AST_ALARM: assert property (
    ok |=> o_general_status_word[6:5] == $past(i_alarm_class))
    else $error("alarm class wrong");
  AST_FLAGS: assert property (
    ok |=> {o_general_status_word[11], o_general_status_word[8:7]} ==
    {$past(i_changeover), $past(i_fixed_stop), $past(i_axis_parking)})
    else $error("general flags wrong");
  AST_FAULT: assert property (
    ok |=> o_motion_status_word[3] == $past(any_fault))
    else $error("fault bit wrong");
  AST_COAST: assert property (
    ok |=> o_motion_status_word[4] != $past(i_coast_stop_command))
    else $error("coast flag wrong");
  AST_QSTOP: assert property (
    ok |=> o_motion_status_word[5] != $past(i_quick_stop_command))
    else $error("quick stop flag wrong");
  AST_SOL: assert property (
    $changed(o_general_status_word[15:12]) |->
    $past(i_telegram_cycle) && o_general_status_word[15:12] ==
    $past(o_general_status_word[15:12]) + 4'h1)
    else $error("sign of life step wrong");
  AST_RSV: assert property (
    o_general_status_word[10:9] == 2'h0)
    else $error("reserved bits set");
endmodule
bind dswa_top dswa_checker #(.FAULT_ENTRIES(FAULT_ENTRIES)) u_chk (
  .i_clock(i_clock), .i_reset(i_reset), .i_telegram_cycle(i_telegram_cycle),
  .i_drive_data_set(i_drive_data_set), .i_alarm_class(i_alarm_class),
  .i_axis_parking(i_axis_parking), .i_fixed_stop(i_fixed_stop),
  .i_changeover(i_changeover), .i_coast_stop_command(i_coast_stop_command),
  .i_quick_stop_command(i_quick_stop_command),
  .i_fault_buffer(i_fault_buffer),
  .o_general_status_word(o_general_status_word),
  .o_motion_status_word(o_motion_status_word));
`default_nettype wire

// ---- bench/dswa_ctrl_model.sv ----
/*
  Supervising controller: issues a telegram cycle on request and keeps
  the general word seen one cycle later.
  Assumes i_go is a one-cycle request.
*/
`timescale 1ns/1ps
`default_nettype none
module dswa_ctrl_model (
  input wire logic i_clock,                      // Clock
  input wire logic i_reset,                      // Reset
  input wire logic i_go,                         // Send telegram
  input wire logic [15:0] i_general_status_word, // From drive
  output logic o_telegram_cycle,                 // Telegram pulse
  output logic [15:0] o_seen_general             // Captured word
);
  logic took_q;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_telegram_cycle <= 1'b0;
      took_q <= 1'b0;
      o_seen_general <= 16'h0000;
    end else begin
      o_telegram_cycle <= i_go;
      took_q <= o_telegram_cycle;
      if (took_q) begin
        o_seen_general <= i_general_status_word;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/dswa_tb_top.sv ----
/*
  Self-checking bench for the drive status word assembler.
  Assumes the top module with default parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module drive_status_word_assembler_tb_top;
  import dswa_pkg::*;
  logic clk = 1'b0;
  logic rst, rd, wr, go, ack, wreq, irq, tel;
  logic [4:0] adr, dset;
  logic [1:0] alc;
  logic [13:0] f;
  logic [7:0] fb;
  logic [31:0] wd, rdata, r;
  logic [15:0] gsw, msw, seen;
  int miscompares = 0;
  int comparisons = 0;
  int seed = 32'h882c;
  int sol, st, ctl, i;
  always #50 clk = ~clk;
  dswa_top DUT (.i_clock(clk), .i_reset(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_irq(irq), .i_telegram_cycle(tel),
    .i_fault_ack(ack), .i_drive_data_set(dset), .i_alarm_class(alc),
    .i_axis_parking(f[0]), .i_fixed_stop(f[1]), .i_changeover(f[2]),
    .i_power_present(f[3]), .i_electronics_ready(f[4]),
    .i_contactor_released(f[5]), .i_pulses_inhibited(f[6]),
    .i_power_stage_on(f[7]), .i_field_building(f[8]),
    .i_switch_on_command(f[9]), .i_pulses_enabled(f[10]),
    .i_ramp_active(f[11]), .i_coast_stop_command(f[12]),
    .i_quick_stop_command(f[13]), .i_fault_buffer(fb),
    .o_general_status_word(gsw), .o_motion_status_word(msw));
  dswa_ctrl_model u_ctrl (.i_clock(clk), .i_reset(rst), .i_go(go),
    .i_general_status_word(gsw), .o_telegram_cycle(tel),
    .o_seen_general(seen));
  function automatic logic [15:0] eg();
    return {4'(sol), f[2], 2'h0, f[1], f[0], alc, dset};
  endfunction
  function automatic logic [15:0] em();
    logic run;
    run = (st == 0);
    return {10'h0, ~f[13], ~f[12], |fb, f[10] & f[11] & f[9] & run,
      f[7] & f[8] & f[9] & run, f[3] & f[4] & f[5] & f[6] & run};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic tg();
    repeat (6) @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    if (ctl == 1) sol = (sol + 1) % 16;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(gsw, eg());
    chk(msw, em());
    chk(seen, eg());
  endtask
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #5000000;
    miscompares++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    {rst, rd, wr, go, ack, adr, wd, dset, alc, f, fb} = '0;
    rst = 1'b1;
    sol = 0;
    st = 0;
    ctl = 1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(0, DSWA_OFF_CONTROL, 32'h0, r);
    chk(r, 32'h1);
    bus(0, DSWA_OFF_IRQ_MASK, 32'h0, r);
    chk(r, 32'h0);
    // Read-only word must ignore writes; unmapped place must read zero
    bus(1, DSWA_OFF_GENERAL, 32'hffff, r);
    bus(0, DSWA_OFF_GENERAL, 32'h0, r);
    chk(r, 32'h0);
    bus(0, 5'h1c, 32'h0, r);
    chk(r, 32'h0);
    $display("test reset done");
    for (i = 0; i < 24; i++) begin
      @(posedge clk);
      dset <= 5'($random(seed));
      alc <= i[1:0];
      f <= 14'($random(seed));
      tg();
      bus(0, DSWA_OFF_GENERAL, 32'h0, r);
      chk(r, {16'h0, eg()});
    end
    $display("test random done");
    bus(1, DSWA_OFF_CONTROL, 32'h3, r);
    ctl = 3;
    tg();
    bus(1, DSWA_OFF_CONTROL, 32'h1, r);
    ctl = 1;
    tg();
    $display("test hold done");
    bus(1, DSWA_OFF_IRQ_MASK, 32'h1, r);
    @(posedge clk);
    f <= 14'h0fff;
    fb <= 8'h10;
    st = 1;
    tg();
    chk({31'h0, irq}, 32'h1);
    bus(1, DSWA_OFF_IRQ_STATUS, 32'h1f, r);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    fb <= 8'h00;
    repeat (6) @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    st = 2;
    tg();
    @(posedge clk);
    f[9] <= 1'b0;
    st = 0;
    tg();
    // Live words follow the settled pins between telegrams
    bus(0, DSWA_OFF_LIVE_MOTION, 32'h0, r);
    chk(r, {16'h0, em()});
    bus(0, DSWA_OFF_LIVE_GENERAL, 32'h0, r);
    chk(r, {16'h0, eg()});
    $display("test fault done");
    close_out();
  end
endmodule
`default_nettype wire
